/* speech_serial_pkg.sv */
package speech_serial_pkg;

  // Data path sizes
  localparam int BYTE_W     = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int CNT_W      = 3;

  // Positions of the pin inputs inside the synchroniser vectors
  localparam int SYNC_W   = 4;
  localparam int SYNC_CSN = 0;
  localparam int SYNC_SCK = 1;
  localparam int SYNC_SI  = 2;
  localparam int SYNC_EPS = 3;

  // Reset values: chip select idles high, all else low; LAST_BIT is the final bit count, 7
  localparam logic [SYNC_W-1:0] SYNC_RST  = 4'h1;
  localparam logic [CNT_W-1:0]  CNT_ZERO  = 3'h0;
  localparam logic [CNT_W-1:0]  LAST_BIT  = 3'h7;
  localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;

endpackage

/* fifo_if.sv */
`timescale 1ns/10ps
interface fifo_if #(
  parameter int WIDTH = 8
);
  logic             pushValid;
  logic             pushReady;
  logic [WIDTH-1:0] pushData;
  logic             popValid;
  logic             popReady;
  logic [WIDTH-1:0] popData;
  logic             pending;

  // Producer and consumer side of the buffer
  modport fill (
    output pushValid,
    output pushData,
    input  pushReady,
    input  popValid,
    input  popData,
    output popReady,
    input  pending
  );

  modport store (
    input  pushValid,
    input  pushData,
    output pushReady,
    output popValid,
    output popData,
    input  popReady,
    output pending
  );
endinterface

/* byte_fifo.sv */
`timescale 1ns/10ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic ref_clk,
  input  wire logic reset_n,
  fifo_if.store     port
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wrPtr;
    logic [AW-1:0]               rdPtr;
    logic [AW:0]                 count;
    logic                        outValid;
    logic [WIDTH-1:0]            outData;
  } fifo_state_t;

  fifo_state_t st;
  fifo_state_t nx;
  logic        doPush;
  logic        doTake;

  // Status toward both sides, all from registers
  assign port.pushReady = (st.count != FULL_COUNT);
  assign port.popValid  = st.outValid;
  assign port.popData   = st.outData;
  assign port.pending   = st.outValid || (st.count != '0);

  // Storage, pointers and registered head word
  always_comb begin
    nx     = st;
    doPush = port.pushValid && port.pushReady;
    doTake = (!st.outValid || port.popReady) && (st.count != '0);
    if (port.popReady && st.outValid) begin
      nx.outValid = 1'b0;
    end
    if (doTake) begin
      nx.outData  = st.mem[st.rdPtr];
      nx.outValid = 1'b1;
      nx.rdPtr    = st.rdPtr + 1'b1;
    end
    if (doPush) begin
      nx.mem[st.wrPtr] = port.pushData;
      nx.wrPtr         = st.wrPtr + 1'b1;
    end
    nx.count = st.count + {{AW{1'b0}}, doPush} - {{AW{1'b0}}, doTake};
  end

  // State register
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= nx;
    end
  end

  // Never more words than the storage holds
  chk_fifo_count_bound: assert property (
    @(posedge ref_clk) disable iff (!reset_n) st.count <= FULL_COUNT)
    else $error("fifo count above depth");

endmodule

/* speech_serial_port.sv */
// Notes on behaviour
// - Edge select low: sample input on rise
// - Edge select high: sample input on fall
// - Edge select low: launch output on fall
// - Edge select high: launch output on rise
// - Transfers happen only while chip select low
// - Chip select high releases serial output
// - Reset holds output released, inputs initial
// - Busy low while a command is pending
// - Reset returns everything to initial state
`timescale 1ns/10ps
module speech_serial_port (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        chip_select_n,
  input  wire logic        serialClk,
  input  wire logic        serialIn,
  input  wire logic        edge_polarity_select,
  output logic             serialOut,
  output logic             serialOutEn,
  output logic             command_busy_n,
  output logic             cmdValid,
  output logic [7:0]       cmdByte,
  input  wire logic        cmdReady
);

  typedef struct packed {
    logic [speech_serial_pkg::SYNC_W-1:0] meta;
    logic [speech_serial_pkg::SYNC_W-1:0] sync;
    logic                                 sckPrev;
    logic [speech_serial_pkg::CNT_W-1:0]  bitCnt;
    logic [speech_serial_pkg::BYTE_W-1:0] rxShift;
    logic [speech_serial_pkg::BYTE_W-1:0] txShift;
    logic [speech_serial_pkg::BYTE_W-1:0] lastCmd;
    logic                                 pushValid;
    logic [speech_serial_pkg::BYTE_W-1:0] pushData;
    logic                                 outData;
    logic                                 outEn;
    logic                                 busyN;
    logic                                 cmdValid;
    logic [speech_serial_pkg::BYTE_W-1:0] cmdByte;
  } port_state_t;

  localparam port_state_t STATE_RST = '{
    meta:      speech_serial_pkg::SYNC_RST,
    sync:      speech_serial_pkg::SYNC_RST,
    sckPrev:   1'b0,
    bitCnt:    speech_serial_pkg::CNT_ZERO,
    rxShift:   speech_serial_pkg::BYTE_ZERO,
    txShift:   speech_serial_pkg::BYTE_ZERO,
    lastCmd:   speech_serial_pkg::BYTE_ZERO,
    pushValid: 1'b0,
    pushData:  speech_serial_pkg::BYTE_ZERO,
    outData:   1'b0,
    outEn:     1'b0,
    busyN:     1'b1,
    cmdValid:  1'b0,
    cmdByte:   speech_serial_pkg::BYTE_ZERO
  };

  port_state_t st;
  port_state_t nx;
  logic        csnS;
  logic        sckS;
  logic        siS;
  logic        epsS;
  logic        sckRise;
  logic        sckFall;
  logic        sampleEdge;
  logic        launchEdge;
  logic        csStart;

  fifo_if #(.WIDTH(speech_serial_pkg::BYTE_W)) fifoIf ();

  ////////////////////////////////////////////////////////////////////////////
  // Command buffer between serial receiver and consumer

  byte_fifo #(
    .WIDTH (speech_serial_pkg::BYTE_W),
    .DEPTH (speech_serial_pkg::FIFO_DEPTH)
  ) cmdFifo (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .port    (fifoIf.store)
  );

  // Buffer connections
  assign fifoIf.pushValid = st.pushValid;
  assign fifoIf.pushData  = st.pushData;
  assign fifoIf.popReady  = !st.cmdValid || cmdReady;

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection on the synchronised pins

  // Second stage only; the first stage feeds nothing else
  assign csnS    = st.sync[speech_serial_pkg::SYNC_CSN];
  assign sckS    = st.sync[speech_serial_pkg::SYNC_SCK];
  assign siS     = st.sync[speech_serial_pkg::SYNC_SI];
  assign epsS    = st.sync[speech_serial_pkg::SYNC_EPS];
  assign sckRise = sckS && !st.sckPrev;
  assign sckFall = !sckS && st.sckPrev;

  // Edge roles picked by the polarity pin, gated by chip select
  assign sampleEdge = !csnS && (epsS ? sckFall : sckRise);
  assign launchEdge = !csnS && (epsS ? sckRise : sckFall);
  assign csStart    = !csnS && !st.outEn;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    nx           = st;
    nx.meta      = {edge_polarity_select, serialIn, serialClk, chip_select_n};
    nx.sync      = st.meta;
    nx.sckPrev   = sckS;
    nx.pushValid = 1'b0;
    nx.outEn     = !csnS;
    // Deselect drops partial bits and parks the output
    if (csnS) begin
      nx.bitCnt  = speech_serial_pkg::CNT_ZERO;
      nx.outData = 1'b0;
    end else if (csStart) begin
      nx.outData = st.lastCmd[speech_serial_pkg::BYTE_W-1];
      nx.txShift = {st.lastCmd[speech_serial_pkg::BYTE_W-2:0], 1'b0};
    end else if (launchEdge) begin
      nx.outData = st.txShift[speech_serial_pkg::BYTE_W-1];
      nx.txShift = {st.txShift[speech_serial_pkg::BYTE_W-2:0], 1'b0};
    end
    // Shift in, MSB first; a full byte goes to the buffer
    if (sampleEdge) begin
      nx.rxShift = {st.rxShift[speech_serial_pkg::BYTE_W-2:0], siS};
      nx.bitCnt  = st.bitCnt + 1'b1;
      if (st.bitCnt == speech_serial_pkg::LAST_BIT) begin
        nx.pushValid = 1'b1;
        nx.pushData  = nx.rxShift;
        nx.lastCmd   = nx.rxShift;
        nx.txShift   = st.lastCmd;
      end
    end
    // Consumer handshake
    if (st.cmdValid && cmdReady) begin
      nx.cmdValid = 1'b0;
    end
    if (fifoIf.popValid && fifoIf.popReady) begin
      nx.cmdValid = 1'b1;
      nx.cmdByte  = fifoIf.popData;
    end
    // Busy while any byte is in flight or unconsumed
    nx.busyN = !(st.pushValid || fifoIf.pending || st.cmdValid);
  end

  // State register; reset loads only constants
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= STATE_RST;
    end else begin
      st <= nx;
    end
  end

  // Outputs straight from flip-flops
  assign serialOut      = st.outData;
  assign serialOutEn    = st.outEn;
  assign command_busy_n = st.busyN;
  assign cmdValid       = st.cmdValid;
  assign cmdByte        = st.cmdByte;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  chk_rise_sample_count: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (!epsS && sckRise && !csnS) |=> st.bitCnt == $past(st.bitCnt) + 1'b1)
    else $error("rising sample not counted");

  chk_fall_sample_bit: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (epsS && sckFall && !csnS) |=> st.rxShift[0] == $past(siS))
    else $error("falling sample bit wrong");

  chk_fall_launch_bit: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (!epsS && sckFall && !csnS && st.outEn)
    |=> serialOut == $past(st.txShift[7]))
    else $error("falling launch bit wrong");

  chk_rise_launch_bit: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (epsS && sckRise && !csnS && st.outEn)
    |=> serialOut == $past(st.txShift[7]))
    else $error("rising launch bit wrong");

  chk_out_steady_between: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (!csnS && st.outEn && !launchEdge) |=> $stable(serialOut))
    else $error("output moved off launch edge");

  chk_push_when_selected: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    $rose(st.pushValid) |-> $past(!csnS))
    else $error("byte taken while deselected");

  chk_out_release_desel: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    csnS |=> !serialOutEn)
    else $error("output driven while deselected");

  chk_reset_outputs: assert property (
    @(posedge ref_clk)
    !reset_n |-> (!serialOutEn && command_busy_n && !cmdValid))
    else $error("outputs not initial in reset");

  chk_busy_pending: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (st.pushValid || fifoIf.pending || st.cmdValid) |=> !command_busy_n)
    else $error("busy not shown while pending");

  chk_desel_drops_bits: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    csnS |=> (st.bitCnt == speech_serial_pkg::CNT_ZERO && !st.pushValid))
    else $error("partial bits kept after deselect");

  chk_cmd_hold: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (cmdValid && !cmdReady) |=> (cmdValid && $stable(cmdByte)))
    else $error("command dropped before taken");

  // Main scenarios
  cov_byte_received: cover property (
    @(posedge ref_clk) disable iff (!reset_n) st.pushValid);
  cov_fall_mode_byte: cover property (
    @(posedge ref_clk) disable iff (!reset_n) st.pushValid && epsS);
  cov_fifo_full: cover property (
    @(posedge ref_clk) disable iff (!reset_n) !fifoIf.pushReady);
  cov_busy_cleared: cover property (
    @(posedge ref_clk) disable iff (!reset_n) $rose(command_busy_n));

endmodule

/* host_serial_model.sv */
`timescale 1ns/10ps
module host_serial_model (
  output logic      chipSelN,
  output logic      sck,
  output logic      sdo,
  output logic      enMissed,
  input  wire logic sdi,
  input  wire logic sdiEn,
  input  wire logic mode
);
  // Host pins idle deselected
  initial begin
    chipSelN = 1'b1;
    sck = 1'b0;
    sdo = 1'b0;
    enMissed = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////
  // One frame, MSB first; clock idles at launch level, 125 ns period
  task automatic frame(input logic [7:0] tx[$], input int nBits,
                       output logic [7:0] rx);
    logic b;
    b = 1'b0;
    enMissed <= 1'b0; // Each frame judged on its own
    sck <= mode;
    #100 chipSelN <= 1'b0;
    #100;
    for (int i = 0; i < nBits; i++) begin
      b = tx[i/8][7-i%8];
      sdo <= b;
      #62.5 sck <= ~mode;
      rx = {rx[6:0], sdiEn ? sdi : ~sdi}; // Released line reads inverted
      enMissed <= enMissed | ~sdiEn;
      #62.5 sck <= mode;
    end
    #100 chipSelN <= 1'b1;
    sdo <= ~b; // Released line shows no stale value
  endtask
endmodule

/* speech_chip_serial_port_tb.sv */
`timescale 1ns/10ps
module speech_chip_serial_port_tb;
  logic       ref_clk;
  logic       reset_n;
  logic       chip_select_n;
  logic       serialClk;
  logic       serialIn;
  logic       edge_polarity_select;
  logic       serialOut;
  logic       serialOutEn;
  logic       command_busy_n;
  logic       cmdValid;
  logic [7:0] cmdByte;
  logic       cmdReady;
  logic       enMissed;
  logic [7:0] rx;
  logic [7:0] got;
  int         n_errors;
  int         compares;
  int         cycles;

  speech_serial_port dut (
    .ref_clk              (ref_clk),
    .reset_n              (reset_n),
    .chip_select_n        (chip_select_n),
    .serialClk            (serialClk),
    .serialIn             (serialIn),
    .edge_polarity_select (edge_polarity_select),
    .serialOut            (serialOut),
    .serialOutEn          (serialOutEn),
    .command_busy_n       (command_busy_n),
    .cmdValid             (cmdValid),
    .cmdByte              (cmdByte),
    .cmdReady             (cmdReady)
  );

  host_serial_model host (
    .chipSelN (chip_select_n),
    .sck      (serialClk),
    .sdo      (serialIn),
    .enMissed (enMissed),
    .sdi      (serialOut),
    .sdiEn    (serialOutEn),
    .mode     (edge_polarity_select)
  );

  //////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 6000) begin
      n_errors++;
      conclude();
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic check(input logic [7:0] seen, exp, input string what);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what,
               seen, exp);
    end
  endtask

  task automatic conclude();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Wait for a byte, bounded, then hand it over
  task automatic take(output logic [7:0] b);
    int n;
    n = 0;
    do @(negedge ref_clk);
    while (cmdValid !== 1'b1 && ++n < 300);
    b = (cmdValid === 1'b1) ? cmdByte : 8'hxx;
    @(posedge ref_clk) cmdReady <= 1'b1;
    @(posedge ref_clk) cmdReady <= 1'b0;
  endtask

  //////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic testMode(input logic m, input logic [7:0] tx, prev);
    @(posedge ref_clk) edge_polarity_select <= m;
    // Device must see the new polarity through its synchroniser before the host parks the clock
    repeat (4) @(posedge ref_clk);
    host.frame({tx}, 8, rx);
    check(rx, prev, "echo");
    check(enMissed, 1'b0, "drive");
    take(got);
    check(got, tx, "byte");
    repeat (5) @(negedge ref_clk);
    check(serialOutEn, 1'b0, "release");
    check(command_busy_n, 1'b1, "idle");
  endtask

  task automatic testPartial();
    host.frame({8'hff}, 5, rx);
    host.frame({8'h5a}, 8, rx);
    take(got);
    check(got, 8'h5a, "partial");
  endtask

  // Eleven bytes into ten places with the consumer stalled
  task automatic testFill();
    logic [7:0] q[$];
    for (int i = 0; i < 11; i++)
      q.push_back(8'h10 + i[7:0]);
    host.frame(q, 88, rx);
    @(negedge ref_clk);
    check(command_busy_n, 1'b0, "busy");
    for (int i = 0; i < 10; i++) begin
      take(got);
      check(got, 8'h10 + i[7:0], "order");
    end
    repeat (20) @(negedge ref_clk);
    check(cmdValid, 1'b0, "overflow");
    check(command_busy_n, 1'b1, "drained");
  endtask

  // Reset in mid-frame with chip select low
  task automatic testReset();
    fork
      host.frame({8'h77}, 8, rx);
      begin
        #500 @(posedge ref_clk) reset_n <= 1'b0;
        @(negedge ref_clk);
        check(serialOutEn, 1'b0, "reset drive");
        check(command_busy_n, 1'b1, "reset busy");
        @(posedge ref_clk) reset_n <= 1'b1;
      end
    join
    repeat (30) @(negedge ref_clk);
    check(cmdValid, 1'b0, "reset byte");
  endtask

  //////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    reset_n = 1'b1;
    cmdReady = 1'b0;
    edge_polarity_select = 1'b0;
    n_errors = 0;
    compares = 0;
    cycles = 0;
    // Late fall so the reset is seen before the first edge
    #1 reset_n = 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(negedge ref_clk);
    check(serialOutEn, 1'b0, "idle drive");
    repeat (5) @(posedge ref_clk);
    testMode(1'b0, 8'ha5, 8'h00);
    testMode(1'b1, 8'h3c, 8'ha5);
    testPartial();
    testFill();
    testReset();
    testMode(1'b0, 8'hc3, 8'h00);
    conclude();
  end
endmodule
